//--- hdl/dcdc_pkg.sv
// Constants, field layouts and decode helpers for the clock and de-emphasis control block.
// Contract
// - Clock mode 00 uses recovered clock and data; 01 uses crystal and aux input.
// - Mode 2 uses recovered clock while locked, crystal and aux input on unlock.
// - Mode 3 always uses crystal and aux input; the PLL keeps running for status.
// - Rate and pre-emphasis come from channel 1, or channel 2 when selected.
// - Consumer byte 3 bits 0-3: 0000, 0100, 1100 give 00, 10, 11; others 01.
// - Professional byte 0 bits 6-7: 10, 00, 01, 11 give 00, 01, 10, 11.
// - Consumer pre-emphasis flag set only when byte 0 matches 0X100.
// - Professional pre-emphasis flag set only when byte 0 bits 2-4 equal 110.
// - Automatic de-emphasis, on by default, follows decoded rate and pre-emphasis.
// - Automatic codes 000, 010, 011, 110 pick 44.1, 48, 32, 96 kHz; others off.
// - Manual codes select the same way when automatic is cleared; reset code 001.
// - Parallel mode always uses automatic de-emphasis from channel 1.
// - Filter is bypassed when pre-emphasis or the selected mode is off.
// - Zero input to the filter may give zero or minus one at the output.
// - Power-down pin low resets everything, stops clocks, refuses register access.
// - Soft reset low clears other settings; only its bit and power bit writable.
// - Partial power-down stops clocks and recovery but keeps settings and access.
// - Input selector 00..11 picks receiver input 1..4 for recovery.
// - Through selector picks the input driving the through output; enable gates it.
// - Parallel mode uses only receiver input 1.
// - High-rate flag follows recovered detection on PLL, programmed bit on crystal.
// - A wrong preamble sync interval counts as unlock.
package dcdc_pkg;

    // Synchronised pin vector layout.
    localparam int SY_PDN = 0;
    localparam int SY_PAR = 1;
    localparam int SY_CM  = 2;
    localparam int SY_PCK = 4;
    localparam int SY_XCK = 5;
    localparam int SY_UNL = 6;
    localparam int SY_RHR = 7;
    localparam int SY_AUX = 8;
    localparam int SY_RX  = 9;
    localparam int SY_W   = 13;

    // Control word layout.
    localparam int CFG_W  = 16;
    localparam int F_SOFT = 0;
    localparam int F_PWR  = 1;
    localparam int F_CM   = 2;
    localparam int F_CHS  = 4;
    localparam int F_AUTO = 5;
    localparam int F_DM   = 6;
    localparam int F_PHR  = 9;
    localparam int F_IPS  = 10;
    localparam int F_OPS  = 12;
    localparam int F_TXE  = 14;
    localparam logic [CFG_W-1:0] CFG_RST  = 16'h4063;
    localparam logic [CFG_W-1:0] CFG_KEEP = 16'h0003;

    localparam int RD_W  = 24;
    localparam int SMP_W = 24;

    // Clock operation modes.
    localparam logic [1:0] CM_PLL  = 2'h0;
    localparam logic [1:0] CM_XTAL = 2'h1;
    localparam logic [1:0] CM_AUTO = 2'h2;
    localparam logic [1:0] CM_MON  = 2'h3;

    // De-emphasis selections.
    localparam logic [2:0] DM_OFF = 3'h0;
    localparam logic [2:0] DM_441 = 3'h1;
    localparam logic [2:0] DM_48  = 3'h2;
    localparam logic [2:0] DM_32  = 3'h3;
    localparam logic [2:0] DM_96  = 3'h4;

    typedef enum logic [3:0] {
        CK_OFF  = 4'h1,
        CK_PLL  = 4'h2,
        CK_XTAL = 4'h4,
        CK_GAP  = 4'h8
    } dcdc_ck_t;

    // Maps {high rate, rate code} or the manual bits onto a filter selection.
    function automatic logic [2:0] dcdc_dm_map(input logic [2:0] code);
        unique case (code)
            3'h0:    dcdc_dm_map = DM_441;
            3'h2:    dcdc_dm_map = DM_48;
            3'h3:    dcdc_dm_map = DM_32;
            3'h6:    dcdc_dm_map = DM_96;
            default: dcdc_dm_map = DM_OFF;
        endcase
    endfunction

endpackage

//--- hdl/dcdc_cs_if.sv
// Carrier for channel status bytes and their decoded rate and pre-emphasis.
`timescale 1ns/10ps
interface dcdc_cs_if;
    logic [7:0] byte0;
    logic [7:0] byte3;
    logic [1:0] rate;
    logic       preemph_flag;
    modport feed (output byte0, output byte3, input rate, input preemph_flag);
    modport dec  (input byte0, input byte3, output rate, output preemph_flag);
endinterface

//--- hdl/dcdc_cs_decode.sv
// Decoder of sampling rate and pre-emphasis from channel status bytes.
`timescale 1ns/10ps
module dcdc_cs_decode
    import dcdc_pkg::*;
(
    dcdc_cs_if.dec cs
);
    logic       pro;
    logic [3:0] con_fs;
    logic [1:0] pro_fs;

    // Bit 0 of byte 0 tells professional from consumer use.
    assign pro    = cs.byte0[0];
    // Patterns are written with the lowest bit first.
    assign con_fs = {cs.byte3[0], cs.byte3[1], cs.byte3[2], cs.byte3[3]};
    assign pro_fs = {cs.byte0[6], cs.byte0[7]};

    always_comb begin
        if (pro) begin
            unique case (pro_fs)
                2'h2:    cs.rate = 2'h0;
                2'h0:    cs.rate = 2'h1;
                2'h1:    cs.rate = 2'h2;
                default: cs.rate = 2'h3;
            endcase
            cs.preemph_flag = ({cs.byte0[2], cs.byte0[3], cs.byte0[4]} == 3'h6);
        end else begin
            unique case (con_fs)
                4'h0:    cs.rate = 2'h0;
                4'h4:    cs.rate = 2'h2;
                4'hc:    cs.rate = 2'h3;
                default: cs.rate = 2'h1;
            endcase
            cs.preemph_flag = !cs.byte0[1] && ({cs.byte0[3], cs.byte0[4], cs.byte0[5]} == 3'h4);
        end
    end
endmodule

//--- hdl/dcdc_ctrl.sv
// Clock source, data source, status decode, de-emphasis and reset control.
`timescale 1ns/10ps
module dcdc_ctrl
    import dcdc_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             power_down_n_i,
    input  wire logic             par_mode_i,
    input  wire logic             clk_mode_sel_hi_i,
    input  wire logic             clk_mode_sel_lo_i,
    input  wire logic             pll_clk_i,
    input  wire logic             crystal_in_i,
    input  wire logic             pll_unlock_i,
    input  wire logic             sync_interval_bad_i,
    input  wire logic             recovered_high_rate_i,
    input  wire logic [3:0]       biphase_inputs_i,
    input  wire logic             aux_audio_in_i,
    input  wire logic             rx_serial_i,
    input  wire logic [SMP_W-1:0] rx_sample_i,
    input  wire logic [SMP_W-1:0] filt_sample_i,
    input  wire logic [7:0]       cs_ch1_byte0_i,
    input  wire logic [7:0]       cs_ch1_byte3_i,
    input  wire logic [7:0]       cs_ch2_byte0_i,
    input  wire logic [7:0]       cs_ch2_byte3_i,
    input  wire logic             cfg_wr_i,
    input  wire logic [CFG_W-1:0] cfg_wdata_i,
    input  wire logic             cfg_rd_i,
    output logic                  master_clk_out_a_o,
    output logic                  master_clk_out_b_o,
    output logic                  pll_run_o,
    output logic                  xtal_run_o,
    output logic                  serial_audio_out_o,
    output logic                  high_rate_flag_o,
    output logic                  rate_code_hi_o,
    output logic                  rate_code_lo_o,
    output logic                  preemph_flag_o,
    output logic [2:0]            deemph_mode_o,
    output logic                  deemph_bypass_o,
    output logic [SMP_W-1:0]      sample_out_o,
    output logic                  recovery_in_o,
    output logic                  thru_out_o,
    output logic                  cfg_rd_valid_o,
    output logic                  cfg_rd_ok_o,
    output logic [RD_W-1:0]       cfg_rd_data_o
);

    typedef struct packed {
        logic [SY_W-1:0]  s1;
        logic [SY_W-1:0]  s2;
        logic [SY_W-1:0]  s3;
        logic [SY_W-1:0]  filt;
        logic [CFG_W-1:0] cfg;
        dcdc_ck_t         ck;
        logic             mclk;
        logic             pll_run;
        logic             xtal_run;
        logic             sdo;
        logic             hr;
        logic             preemph_flag;
        logic [1:0]       rate;
        logic [2:0]       dm;
        logic             bypass;
        logic [SMP_W-1:0] smp;
        logic             rec_in;
        logic             thru;
        logic             rd_valid;
        logic             rd_ok;
        logic [RD_W-1:0]  rd_data;
    } dcdc_st_t;

    localparam dcdc_st_t ST_RST = '{
        s1: '0, s2: '0, s3: '0, filt: '0, cfg: CFG_RST, ck: CK_OFF,
        mclk: 1'b0, pll_run: 1'b0, xtal_run: 1'b0, sdo: 1'b0, hr: 1'b0,
        preemph_flag: 1'b0, rate: 2'h0, dm: DM_OFF, bypass: 1'b1, smp: '0,
        rec_in: 1'b0, thru: 1'b0, rd_valid: 1'b0, rd_ok: 1'b0, rd_data: '0
    };

    dcdc_st_t r_ff;
    dcdc_st_t nxt_r;

    dcdc_cs_if cs_if ();

    dcdc_cs_decode u_dec (
        .cs (cs_if)
    );

    logic [SY_W-1:0] pins;
    logic            pdn_ok;
    logic            par;
    logic            soft_ok;
    logic            run;
    logic [1:0]      mode;
    logic            unlock;
    logic            pll_on;
    logic            xtal_on;
    logic            want_pll;
    logic            locked;
    logic            auto_eff;
    logic            chsel;
    logic [1:0]      ips;
    logic [3:0]      rx_vec;
    logic            pck;
    logic            xck;
    logic            rd_allow;

    // Every pin enters through three flops; the middle and last must agree.
    assign pins = {biphase_inputs_i, aux_audio_in_i, recovered_high_rate_i, pll_unlock_i,
                   crystal_in_i, pll_clk_i, clk_mode_sel_hi_i, clk_mode_sel_lo_i,
                   par_mode_i, power_down_n_i};

    assign pdn_ok   = r_ff.filt[SY_PDN];
    assign par      = r_ff.filt[SY_PAR];
    assign soft_ok  = r_ff.cfg[F_SOFT];
    assign run      = pdn_ok && soft_ok && r_ff.cfg[F_PWR];
    // Pins steer the clock mode in parallel mode, the control word otherwise.
    assign mode     = par ? r_ff.filt[SY_CM+:2] : r_ff.cfg[F_CM+:2];
    assign unlock   = r_ff.filt[SY_UNL] || sync_interval_bad_i;
    assign pll_on   = run && (mode != CM_XTAL);
    assign xtal_on  = run && (mode != CM_PLL);
    assign want_pll = (mode == CM_PLL) || ((mode == CM_AUTO) && !unlock);
    assign locked   = pll_on && !unlock;
    assign auto_eff = par || r_ff.cfg[F_AUTO];
    assign chsel    = !par && r_ff.cfg[F_CHS];
    assign ips      = par ? 2'h0 : r_ff.cfg[F_IPS+:2];
    assign rx_vec   = r_ff.filt[SY_RX+:4];
    assign pck      = r_ff.filt[SY_PCK];
    assign xck      = r_ff.filt[SY_XCK];
    assign rd_allow = pdn_ok && soft_ok && !par;

    assign cs_if.byte0 = chsel ? cs_ch2_byte0_i : cs_ch1_byte0_i;
    assign cs_if.byte3 = chsel ? cs_ch2_byte3_i : cs_ch1_byte3_i;

    always_comb begin
        nxt_r      = r_ff;
        nxt_r.s1   = pins;
        nxt_r.s2   = r_ff.s1;
        nxt_r.s3   = r_ff.s2;
        nxt_r.filt = (r_ff.s2 & r_ff.s3) | (r_ff.filt & (r_ff.s2 ^ r_ff.s3));

        // Control word: power-down resets it, soft reset guards all but two bits.
        if (!pdn_ok) begin
            nxt_r.cfg = CFG_RST;
        end else if (cfg_wr_i && !par) begin
            if (soft_ok) begin
                nxt_r.cfg = cfg_wdata_i;
            end else begin
                nxt_r.cfg = (r_ff.cfg & ~CFG_KEEP) | (cfg_wdata_i & CFG_KEEP);
            end
            if (!nxt_r.cfg[F_SOFT]) begin
                nxt_r.cfg = (CFG_RST & ~CFG_KEEP) | (nxt_r.cfg & CFG_KEEP);
            end
        end

        // Status bits hold their last value while the receiver is unlocked.
        if (!pdn_ok || !soft_ok) begin
            nxt_r.rate = 2'h0;
            nxt_r.preemph_flag  = 1'b0;
        end else if (locked) begin
            nxt_r.rate = cs_if.rate;
            nxt_r.preemph_flag  = cs_if.preemph_flag;
        end

        if (!pdn_ok) begin
            nxt_r.hr = 1'b0;
        end else if (want_pll) begin
            nxt_r.hr = r_ff.filt[SY_RHR];
        end else begin
            nxt_r.hr = r_ff.cfg[F_PHR];
        end

        // Selection is made only with pre-emphasis present in the stream.
        if (!r_ff.preemph_flag) begin
            nxt_r.dm = DM_OFF;
        end else if (auto_eff) begin
            nxt_r.dm = dcdc_dm_map({r_ff.hr, r_ff.rate});
        end else begin
            nxt_r.dm = dcdc_dm_map(r_ff.cfg[F_DM+:3]);
        end
        nxt_r.bypass = (nxt_r.dm == DM_OFF);
        // Zero input may leave the filter at minus one, so no zero forcing here.
        nxt_r.smp = r_ff.bypass ? rx_sample_i : filt_sample_i;

        nxt_r.sdo      = run && (want_pll ? rx_serial_i : r_ff.filt[SY_AUX]);
        nxt_r.pll_run  = pll_on;
        nxt_r.xtal_run = xtal_on;
        nxt_r.rec_in   = pdn_ok && rx_vec[ips];
        nxt_r.thru     = pdn_ok && !par && r_ff.cfg[F_TXE]
                         && rx_vec[r_ff.cfg[F_OPS+:2]];

        // Source changes pass through a low gap, entered and left on low levels only.
        unique case (r_ff.ck)
            CK_OFF: begin
                if (run && want_pll && !pck) begin
                    nxt_r.ck = CK_PLL;
                end else if (run && !want_pll && !xck) begin
                    nxt_r.ck = CK_XTAL;
                end
            end
            CK_PLL: begin
                if ((!run || !want_pll) && !pck) begin
                    nxt_r.ck = CK_GAP;
                end
            end
            CK_XTAL: begin
                if ((!run || want_pll) && !xck) begin
                    nxt_r.ck = CK_GAP;
                end
            end
            CK_GAP: begin
                nxt_r.ck = CK_OFF;
            end
            default: begin
                nxt_r.ck = CK_OFF;
            end
        endcase
        nxt_r.mclk = ((nxt_r.ck == CK_PLL) && pck) || ((nxt_r.ck == CK_XTAL) && xck);

        // Refused reads still answer, with the ok flag low and zero data.
        nxt_r.rd_valid = cfg_rd_i;
        nxt_r.rd_ok    = cfg_rd_i && rd_allow;
        if (cfg_rd_i && rd_allow) begin
            nxt_r.rd_data = {3'h0, r_ff.hr, unlock, r_ff.preemph_flag, r_ff.rate, r_ff.cfg};
        end else begin
            nxt_r.rd_data = '0;
        end

        if (!pdn_ok) begin
            nxt_r.ck   = CK_OFF;
            nxt_r.mclk = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_ff <= ST_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign master_clk_out_a_o = r_ff.mclk;
    assign master_clk_out_b_o = r_ff.mclk;
    assign pll_run_o          = r_ff.pll_run;
    assign xtal_run_o         = r_ff.xtal_run;
    assign serial_audio_out_o = r_ff.sdo;
    assign high_rate_flag_o   = r_ff.hr;
    assign rate_code_hi_o     = r_ff.rate[1];
    assign rate_code_lo_o     = r_ff.rate[0];
    assign preemph_flag_o     = r_ff.preemph_flag;
    assign deemph_mode_o      = r_ff.dm;
    assign deemph_bypass_o    = r_ff.bypass;
    assign sample_out_o       = r_ff.smp;
    assign recovery_in_o      = r_ff.rec_in;
    assign thru_out_o         = r_ff.thru;
    assign cfg_rd_valid_o     = r_ff.rd_valid;
    assign cfg_rd_ok_o        = r_ff.rd_ok;
    assign cfg_rd_data_o      = r_ff.rd_data;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    rate_consumer_a: assert property (
        $past(locked && soft_ok && !cs_if.byte0[0]
              && {cs_if.byte3[0], cs_if.byte3[1], cs_if.byte3[2], cs_if.byte3[3]} == 4'h4)
        |-> {rate_code_hi_o, rate_code_lo_o} == 2'h2)
        else $error("consumer rate code wrong");

    rate_pro_a: assert property (
        $past(locked && soft_ok && cs_if.byte0[0] && !cs_if.byte0[7] && cs_if.byte0[6])
        |-> {rate_code_hi_o, rate_code_lo_o} == 2'h0)
        else $error("professional rate code wrong");

    pem_consumer_a: assert property (
        $past(locked && soft_ok && !cs_if.byte0[0])
        |-> preemph_flag_o == $past(!cs_if.byte0[1] && cs_if.byte0[3]
                                    && !cs_if.byte0[4] && !cs_if.byte0[5]))
        else $error("consumer pre-emphasis flag wrong");

    pem_pro_a: assert property (
        $past(locked && soft_ok && cs_if.byte0[0])
        |-> preemph_flag_o == $past(cs_if.byte0[2] && cs_if.byte0[3] && !cs_if.byte0[4]))
        else $error("professional pre-emphasis flag wrong");

    deemph_auto_a: assert property (
        (auto_eff && preemph_flag_o && high_rate_flag_o && rate_code_hi_o && !rate_code_lo_o)
        |=> deemph_mode_o == DM_96 && !deemph_bypass_o)
        else $error("automatic 96 kHz selection missed");

    deemph_manual_a: assert property (
        (!auto_eff && preemph_flag_o && r_ff.cfg[F_DM+:3] == 3'h1) |=> deemph_bypass_o)
        else $error("manual off code did not bypass");

    bypass_data_a: assert property (
        deemph_bypass_o |=> sample_out_o == $past(rx_sample_i))
        else $error("bypass altered the samples");

    pdn_read_a: assert property (
        (!pdn_ok && cfg_rd_i) |=> cfg_rd_valid_o && !cfg_rd_ok_o && cfg_rd_data_o == '0)
        else $error("read served during power-down");

    soft_guard_a: assert property (
        (pdn_ok && !soft_ok) |=> r_ff.cfg[CFG_W-1:2] == CFG_RST[CFG_W-1:2])
        else $error("settings written under soft reset");

    mode2_aux_a: assert property (
        (run && mode == CM_AUTO && unlock) |=> serial_audio_out_o == $past(r_ff.filt[SY_AUX]))
        else $error("unlocked mode 2 did not use aux data");

    clk_gap_a: assert property (
        (r_ff.ck == CK_PLL ##1 r_ff.ck != CK_PLL) |-> !master_clk_out_a_o ##1 !master_clk_out_a_o)
        else $error("master clock runt on source change");

    mode0_src_a: assert property (
        (run && mode == CM_PLL) |=> pll_run_o && !xtal_run_o)
        else $error("clock mode 0 oscillator enables wrong");

    mode1_src_a: assert property (
        (run && mode == CM_XTAL) |=> !pll_run_o && xtal_run_o
            && serial_audio_out_o == $past(r_ff.filt[SY_AUX]))
        else $error("clock mode 1 source wrong");

    mode3_src_a: assert property (
        (run && mode == CM_MON) |=> pll_run_o && xtal_run_o
            && serial_audio_out_o == $past(r_ff.filt[SY_AUX]))
        else $error("clock mode 3 source wrong");

    hr_prog_a: assert property (
        (pdn_ok && !want_pll) |=> high_rate_flag_o == $past(r_ff.cfg[F_PHR]))
        else $error("crystal high-rate flag not the programmed bit");

    part_power_a: assert property (
        (pdn_ok && !r_ff.cfg[F_PWR]) |=> !pll_run_o && !xtal_run_o)
        else $error("partial power-down left oscillators running");

    pdn_clock_a: assert property (
        !pdn_ok |=> !master_clk_out_a_o && !master_clk_out_b_o && !pll_run_o && !xtal_run_o)
        else $error("clocks running in power-down");

    rx_select_a: assert property (
        (pdn_ok && !par) |=> recovery_in_o == $past(rx_vec[r_ff.cfg[F_IPS+:2]]))
        else $error("recovery input not the selected one");

    par_input_a: assert property (
        (pdn_ok && par) |=> recovery_in_o == $past(rx_vec[0]) && !thru_out_o)
        else $error("parallel mode used another receiver input");

    thru_off_a: assert property (
        !r_ff.cfg[F_TXE] |=> !thru_out_o)
        else $error("through output ran while disabled");

    pem_bypass_a: assert property (
        !preemph_flag_o |=> deemph_bypass_o && deemph_mode_o == DM_OFF)
        else $error("filter engaged without pre-emphasis");

endmodule

//--- test/dcdc_src_model.sv
// Behavioural biphase source standing on the receiver side of the control block.
`timescale 1ns/10ps
module dcdc_src_model (
    input  wire logic        clk_i,
    input  wire logic        run_i,
    input  wire logic [3:0]  pat_i,
    output logic             pll_clk_o,
    output logic [3:0]       bits_o,
    output logic             rx_serial_o,
    output logic [23:0]      rx_sample_o
);
    logic [23:0] cnt_ff = 24'h000000;

    always @(posedge clk_i) begin
        cnt_ff <= cnt_ff + 24'h000001;
    end

    // The recovered clock stands still while run_i is low.
    assign pll_clk_o   = run_i & cnt_ff[1];
    // Released lines toggle every cycle so that a stale level never passes for data.
    assign bits_o      = run_i ? pat_i : {4{cnt_ff[0]}};
    assign rx_serial_o = run_i | cnt_ff[0];
    assign rx_sample_o = cnt_ff ^ 24'h5a5a5a;
endmodule

//--- test/dcdc_ctrl_bench.sv
// Self-checking bench for the clock, status and de-emphasis control block.
`timescale 1ns/10ps
module dcdc_ctrl_bench;
    import dcdc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        power_down_n = 1'b0, par = 1'b0, xtal = 1'b0, unl = 1'b0, sib = 1'b0, rhr = 1'b0;
    logic        aux = 1'b0, run = 1'b1, wr = 1'b0, rd = 1'b0, xph = 1'b0;
    logic [1:0]  cmp = 2'h0;
    logic [3:0]  pat = 4'h0;
    logic [7:0]  b0a = 8'h00, b3a = 8'h00, b0b = 8'h00, b3b = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic        mca, mcb, pllr, xr, sdo, hr, rh, rl, preemph_flag, byp, rin, thru, rv, rok, pllc, rxs;
    logic [2:0]  dm, em;
    logic [3:0]  bits;
    logic [23:0] so, rdat, rxsm, smp_d;
    int          bad_count = 0, n_tests = 0, h;
    // Rows: high rate, byte 0, byte 3, then a nibble of {0, rate, pre-emphasis}.
    localparam logic [23:0] ST_TAB [13] = '{24'h008001, 24'h00c025, 24'h008037, 24'h008013,
        24'h018000, 24'h00a024, 24'h04d001, 24'h00d003, 24'h08d005, 24'h0cd007, 24'h045000,
        24'h108025, 24'h108001};
    // Rows: clock mode, unlock, bad sync, then pll run, crystal run, high rate, data.
    localparam logic [7:0]  CM_TAB [6] = '{8'h0b, 8'h44, 8'h8f, 8'hac, 8'h9c, 8'hcc};

    dcdc_src_model dcdc_src_model_i (.clk_i(clk_i), .run_i(run), .pat_i(pat), .pll_clk_o(pllc),
        .bits_o(bits), .rx_serial_o(rxs), .rx_sample_o(rxsm));
    dcdc_ctrl dcdc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .power_down_n_i(power_down_n), .par_mode_i(par),
        .clk_mode_sel_hi_i(cmp[1]), .clk_mode_sel_lo_i(cmp[0]), .pll_clk_i(pllc),
        .crystal_in_i(xtal), .pll_unlock_i(unl), .sync_interval_bad_i(sib),
        .recovered_high_rate_i(rhr), .biphase_inputs_i(bits), .aux_audio_in_i(aux),
        .rx_serial_i(rxs), .rx_sample_i(rxsm), .filt_sample_i(~rxsm), .cs_ch1_byte0_i(b0a),
        .cs_ch1_byte3_i(b3a), .cs_ch2_byte0_i(b0b), .cs_ch2_byte3_i(b3b), .cfg_wr_i(wr),
        .cfg_wdata_i(wd), .cfg_rd_i(rd), .master_clk_out_a_o(mca), .master_clk_out_b_o(mcb),
        .pll_run_o(pllr), .xtal_run_o(xr), .serial_audio_out_o(sdo), .high_rate_flag_o(hr),
        .rate_code_hi_o(rh), .rate_code_lo_o(rl), .preemph_flag_o(preemph_flag), .deemph_mode_o(dm),
        .deemph_bypass_o(byp), .sample_out_o(so), .recovery_in_o(rin), .thru_out_o(thru),
        .cfg_rd_valid_o(rv), .cfg_rd_ok_o(rok), .cfg_rd_data_o(rdat));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // The crystal runs at a quarter of the clock rate, slow enough for the pin filter.
    always @(negedge clk_i) begin
        xph  <= ~xph;
        xtal <= xtal ^ xph;
    end
    // Sample that the design registered at the latest rising edge.
    always @(posedge clk_i) begin
        smp_d <= rxsm;
    end

    function automatic logic [2:0] exp_dm(input logic [2:0] c);
        case (c)
            3'h0: return DM_441;
            3'h2: return DM_48;
            3'h3: return DM_32;
            3'h6: return DM_96;
            default: return DM_OFF;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic wcfg(input logic [15:0] v);
        @(negedge clk_i);
        wr = 1'b1;
        wd = v;
        @(negedge clk_i);
        wr = 1'b0;
    endtask

    // A refused read must still answer, with zero data.
    task automatic rcfg(input logic ok, input logic [15:0] exp);
        @(negedge clk_i);
        rd = 1'b1;
        @(negedge clk_i);
        rd = 1'b0;
        chk("rd_valid", rv, 1);
        chk("rd_ok", rok, ok);
        chk("rd_data", ok ? {8'h00, rdat[15:0]} : rdat, {8'h00, exp});
    endtask

    task automatic mcount(output int n);
        n = 0;
        repeat (16) begin
            @(negedge clk_i);
            n += int'(mca);
        end
    endtask

    task automatic done(input string s);
        $display("test %s ended, mismatches %0d", s, bad_count);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        conclude;
    end

    initial begin
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        rcfg(1'b0, 16'h0000);
        chk("bypass", byp, 1);
        power_down_n = 1'b1;
        wt(8);
        rcfg(1'b1, 16'h4063);
        done("reset");
        foreach (ST_TAB[k]) begin
            rhr = ST_TAB[k][20];
            b0a = ST_TAB[k][19:12];
            b3a = ST_TAB[k][11:4];
            wt(10);
            em = ST_TAB[k][0] ? exp_dm({rhr, ST_TAB[k][2:1]}) : DM_OFF;
            chk("rate", {rh, rl}, ST_TAB[k][2:1]);
            chk("pem", preemph_flag, ST_TAB[k][0]);
            chk("dm", dm, em);
            chk("bypass", byp, em == DM_OFF);
            chk("sample", so, (em == DM_OFF) ? smp_d : ~smp_d);
        end
        done("status");
        rhr = 1'b1;
        foreach (CM_TAB[k]) begin
            wcfg(16'h4063 | {12'h000, CM_TAB[k][7:6], 2'h0});
            unl = CM_TAB[k][5];
            sib = CM_TAB[k][4];
            run = !CM_TAB[k][5];
            wt(10);
            chk("pll_run", pllr, CM_TAB[k][3]);
            chk("xtal_run", xr, CM_TAB[k][2]);
            chk("high_rate", hr, CM_TAB[k][1]);
            chk("sdata", sdo, CM_TAB[k][0]);
            chk("mclk_pair", mca, mcb);
        end
        unl = 1'b0;
        sib = 1'b0;
        wcfg(16'h4267);
        wt(10);
        chk("high_rate", hr, 1);
        mcount(h);
        chk("mclk_xtal", h[23:0], 8);
        done("clock modes");
        for (int s = 0; s < 4; s++) begin
            wcfg(16'h4063 | {2'h0, s[1:0], s[1:0], 10'h000});
            pat = 4'h1 << s;
            wt(8);
            chk("rx_sel", rin, 1);
            chk("thru", thru, 1);
            pat = ~(4'h1 << s);
            wt(8);
            chk("rx_sel", rin, 0);
            chk("thru", thru, 0);
        end
        wcfg(16'h0063);
        pat = 4'hf;
        wt(8);
        chk("thru_off", thru, 0);
        done("selects");
        b0a = 8'h18;
        b3a = 8'h00;
        b0b = 8'h08;
        b3b = 8'h03;
        wcfg(16'h4073);
        wt(10);
        chk("rate", {rh, rl}, 2'h3);
        chk("pem", preemph_flag, 1);
        for (int c = 0; c < 8; c++) begin
            wcfg(16'h4013 | {7'h00, c[2:0], 6'h00});
            wt(6);
            chk("dm", dm, exp_dm(c[2:0]));
        end
        done("manual");
        // Manual code 000 and channel 2 would both give filtering, so off proves the override.
        wcfg(16'h4c13);
        par = 1'b1;
        cmp = 2'h3;
        pat = 4'h1;
        wt(10);
        chk("dm", dm, DM_OFF);
        chk("pem", preemph_flag, 0);
        chk("rx_sel", rin, 1);
        chk("pll_run", pllr, 1);
        chk("sdata", sdo, 0);
        rcfg(1'b0, 16'h0000);
        par = 1'b0;
        cmp = 2'h0;
        wt(8);
        done("parallel");
        wcfg(16'h7ffe);
        wt(3);
        rcfg(1'b0, 16'h0000);
        chk("pem", preemph_flag, 0);
        wcfg(16'h0003);
        rcfg(1'b1, 16'h4063);
        wcfg(16'h4071);
        rcfg(1'b1, 16'h4071);
        wt(4);
        mcount(h);
        chk("mclk_stop", h[23:0], 0);
        wcfg(16'h4073);
        wt(10);
        mcount(h);
        chk("mclk_run", h != 0, 1);
        power_down_n = 1'b0;
        wt(8);
        rcfg(1'b0, 16'h0000);
        mcount(h);
        chk("mclk_down", h[23:0], 0);
        wcfg(16'h4077);
        power_down_n = 1'b1;
        wt(8);
        rcfg(1'b1, 16'h4063);
        done("resets");
        conclude;
    end
endmodule
